/* rtl/pirs_pkg.sv */
// Package for the transceiver pin logic: register addresses, field positions,
// reset values and cycle counts shared by the pin block and its memory.
// Assumes a single 20 MHz system clock and 16-bit management registers.
package pirs_pkg;
   // Register addresses on the management bus.
   localparam logic [4:0] PIRS_ADDR_INT_CTRL = 5'h1b;
   localparam logic [4:0] PIRS_ADDR_PHY_CTRL = 5'h1f;
   // Interrupt polarity bit in the control register.
   localparam int PIRS_POL_BIT = 14;
   // Reset value of the polarity register: active-low interrupt.
   localparam logic [15:0] PIRS_PHY_CTRL_RST = 16'h0000;
   // Reset value of the interrupt control register.
   localparam logic [15:0] PIRS_INT_CTRL_RST = 16'h0000;
   // Enable bits sit in the high byte, status in the low byte.
   localparam int PIRS_EN_LSB = 8;
   // Pin option value that turns the shared pin into a wake event output.
   localparam logic [1:0] PIRS_PIN_OPT_WAKE = 2'h2;
   // Mode strap codes.
   localparam logic [3:0] PIRS_MODE_NAND = 4'h4;
   localparam logic [3:0] PIRS_MODE_PDOWN = 4'h7;
   // Core clock rate and the number of bits in one management frame.
   localparam int PIRS_CLK_HZ = 20_000_000;
   localparam int PIRS_MGMT_OP_CYCLES = 32;
   // Management frame opcodes.
   localparam logic [1:0] PIRS_OP_WRITE = 2'h1;
   localparam logic [1:0] PIRS_OP_READ = 2'h2;
endpackage : pirs_pkg

/* rtl/pirs_regmem.sv */
// Small register memory for the management registers of the pin block.
// Assumes one write port and one registered read port on the system clock.
`timescale 1ns/10ps
`default_nettype none
module pirs_regmem #(
   parameter int DEPTH = 32
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [4:0] rd_addr,
   output logic [15:0] rd_data
);
   import pirs_pkg::*;
   // Storage words, reset to zero.
   logic [15:0] mem_reg [DEPTH];
   // The address ports are five bits wide, so any other depth leaves words unreachable or out of range.
   if (DEPTH != 32)
   begin : g_depth_check
      $error("pirs_regmem needs DEPTH 32.");
   end
   // Write port.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < DEPTH; i++) mem_reg[i] <= 16'h0000;
      end
      else if (wr_en)
      begin
         mem_reg[wr_addr] <= wr_data;
      end
   end
   // Read data comes from a register so it is stable for a whole cycle.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rd_data <= 16'h0000;
      end
      else
      begin
         rd_data <= mem_reg[rd_addr];
      end
   end
endmodule : pirs_regmem
`default_nettype wire

/* rtl/pirs_pins.sv */
// Pin logic of the transceiver: management serial port, interrupt/wake pin,
// 125 MHz clock output enable and strap capture.
// Assumes clk is the core clock; mgmt clock and data arrive asynchronously.
// Operation
// - Management data timed by management clock input.
// - Register 1Bh programs and reports interrupts.
// - Register 1Fh bit 14 sets polarity.
// - Pin option 2 gives low wake event.
// - Shared pin always driven both ways.
// - Optional 125 MHz clock output for MAC.
// - Active-low reset; straps taken at release.
// - Address strap three bits, top bits zero.
// - Mode strap: 0100 NAND, 0111 power-down.
`timescale 1ns/10ps
`default_nettype none
module pirs_pins
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mgmt_clk,
   input wire logic mgmt_data_in,
   output logic mgmt_data_out,
   output logic mgmt_data_oe_b,
   input wire logic [7:0] int_events,
   input wire logic wake_event,
   input wire logic [1:0] pin_option,
   output logic int_pin_out,
   output logic int_pin_oe_b,
   input wire logic ref_clock_125_in,
   input wire logic ref_clock_125_strap_in,
   input wire logic ref_clock_125_en_strap,
   output logic ref_clock_125_out,
   output logic ref_clock_125_oe_b,
   input wire logic [2:0] mgmt_address_strap,
   input wire logic [3:0] mode_strap,
   output logic led_behaviour_strap,
   output logic [4:0] mgmt_address,
   output logic nand_tree_mode,
   output logic power_down_mode
);
   import pirs_pkg::*;
   // Three-stage synchronisers for the management clock and data.
   logic [2:0] mclk_sync_reg;
   logic [2:0] mdat_sync_reg;
   logic mclk_state_reg;
   logic mdat_state_reg;
   logic mclk_rise;
   logic mclk_fall;
   // Serial engine state.
   logic [5:0] bit_cnt_reg;
   logic [31:0] shift_reg;
   logic [15:0] tx_reg;
   logic tx_active_reg;
   logic [4:0] reg_addr_reg;
   logic [15:0] int_ctrl_reg;
   logic [15:0] phy_ctrl_reg;
   logic [15:0] rd_data;
   logic wr_en;
   logic strap_taken_reg;
   // Synchronise both inputs; a change counts once stages two and three agree.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         mclk_sync_reg <= 3'h0;
         mdat_sync_reg <= 3'h0;
      end
      else
      begin
         mclk_sync_reg <= {mclk_sync_reg[1:0], mgmt_clk};
         mdat_sync_reg <= {mdat_sync_reg[1:0], mgmt_data_in};
      end
   end
   // Filtered levels update only when the two late stages match.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         mclk_state_reg <= 1'b0;
         mdat_state_reg <= 1'b1;
      end
      else
      begin
         if (mclk_sync_reg[1] == mclk_sync_reg[2]) mclk_state_reg <= mclk_sync_reg[2];
         if (mdat_sync_reg[1] == mdat_sync_reg[2]) mdat_state_reg <= mdat_sync_reg[2];
      end
   end
   assign mclk_rise = (mclk_sync_reg[2:1] == 2'b11) && !mclk_state_reg;
   assign mclk_fall = (mclk_sync_reg[2:1] == 2'b00) && mclk_state_reg;
   // Frame engine: after preamble of ones, a start 01 begins a 32-bit frame.
   // Data is taken on management clock rising edges only.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         bit_cnt_reg <= 6'h00;
         shift_reg <= 32'h0000_0000;
         reg_addr_reg <= 5'h00;
      end
      else if (mclk_rise)
      begin
         shift_reg <= {shift_reg[30:0], mdat_state_reg};
         if (bit_cnt_reg == 6'h00)
         begin
            // Wait for start pattern 0 then 1 after idle ones.
            if (shift_reg[0] == 1'b0 && mdat_state_reg && shift_reg[1]) bit_cnt_reg <= 6'h02;
         end
         else if (bit_cnt_reg == 6'(PIRS_MGMT_OP_CYCLES - 1))
         begin
            bit_cnt_reg <= 6'h00;
         end
         else
         begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         end
         // The register address occupies frame bits 9 to 13; it is complete on bit 13.
         if (bit_cnt_reg == 6'h0d) reg_addr_reg <= {shift_reg[3:0], mdat_state_reg};
      end
   end
   // A write completes on the last bit of a write frame.
   assign wr_en = mclk_rise && (bit_cnt_reg == 6'(PIRS_MGMT_OP_CYCLES - 1))
                  && (shift_reg[28:27] == PIRS_OP_WRITE);
   // Register storage for the other addresses lives in the memory module.
   pirs_regmem #(.DEPTH(32)) u_mem
   (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(wr_en),
      .wr_addr(reg_addr_reg),
      .wr_data({shift_reg[14:0], mdat_state_reg}),
      .rd_addr(reg_addr_reg),
      .rd_data(rd_data)
   );
   // Interrupt control: enables written, status sticky; set wins over clear.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         int_ctrl_reg <= PIRS_INT_CTRL_RST;
      end
      else
      begin
         if (wr_en && reg_addr_reg == PIRS_ADDR_INT_CTRL)
            int_ctrl_reg[15:8] <= shift_reg[14:7];
         // Reading the status clears it, but new events still land.
         if (mclk_fall && bit_cnt_reg == 6'h10 && reg_addr_reg == PIRS_ADDR_INT_CTRL
             && shift_reg[13:12] == PIRS_OP_READ)
            int_ctrl_reg[7:0] <= int_events;
         else
            int_ctrl_reg[7:0] <= int_ctrl_reg[7:0] | int_events;
      end
   end
   // Polarity register.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         phy_ctrl_reg <= PIRS_PHY_CTRL_RST;
      end
      else if (wr_en && reg_addr_reg == PIRS_ADDR_PHY_CTRL)
      begin
         phy_ctrl_reg <= {shift_reg[14:0], mdat_state_reg};
      end
   end
   // Turnaround load and shift-out of read data on falling edges.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         tx_reg <= 16'h0000;
         tx_active_reg <= 1'b0;
      end
      else if (mclk_fall)
      begin
         // At the turnaround the opcode sits in frame bits 2 and 3, that is shift_reg[13:12].
         if (bit_cnt_reg == 6'h10 && shift_reg[13:12] == PIRS_OP_READ)
         begin
            tx_active_reg <= 1'b1;
            if (reg_addr_reg == PIRS_ADDR_INT_CTRL) tx_reg <= int_ctrl_reg;
            else if (reg_addr_reg == PIRS_ADDR_PHY_CTRL) tx_reg <= phy_ctrl_reg;
            else tx_reg <= rd_data;
         end
         else if (tx_active_reg)
         begin
            tx_reg <= {tx_reg[14:0], 1'b0};
            if (bit_cnt_reg == 6'h00) tx_active_reg <= 1'b0;
         end
      end
   end
   assign mgmt_data_out = tx_reg[15];
   assign mgmt_data_oe_b = !tx_active_reg;
   // Interrupt or wake pin, always driven in both directions.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         int_pin_out <= 1'b1;
      end
      else if (pin_option == PIRS_PIN_OPT_WAKE)
      begin
         int_pin_out <= !wake_event;
      end
      else
      begin
         // Held active while any enabled status stays set.
         int_pin_out <= (|(int_ctrl_reg[7:0] & int_ctrl_reg[15:8])) ^ !phy_ctrl_reg[PIRS_POL_BIT];
      end
   end
   assign int_pin_oe_b = 1'b0;
   // Strap capture at the first clock after reset release.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         strap_taken_reg <= 1'b0;
         led_behaviour_strap <= 1'b0;
         mgmt_address <= 5'h00;
         nand_tree_mode <= 1'b0;
         power_down_mode <= 1'b0;
         ref_clock_125_oe_b <= 1'b1;
      end
      else if (!strap_taken_reg)
      begin
         strap_taken_reg <= 1'b1;
         led_behaviour_strap <= ref_clock_125_strap_in;
         mgmt_address <= {2'b00, mgmt_address_strap};
         nand_tree_mode <= (mode_strap == PIRS_MODE_NAND);
         power_down_mode <= (mode_strap == PIRS_MODE_PDOWN);
         ref_clock_125_oe_b <= !ref_clock_125_en_strap;
      end
   end
   // The 125 MHz clock comes from the analog PLL; it is only gated here.
   assign ref_clock_125_out = ref_clock_125_in & !ref_clock_125_oe_b;
   // Polarity default is active low after reset.
   pol_rst_a: assert property (@(posedge clk) $rose(rst_b) |-> !phy_ctrl_reg[PIRS_POL_BIT])
      else $error("Polarity not active low after reset.");
   pin_drive_a: assert property (@(posedge clk) disable iff (!rst_b) !int_pin_oe_b)
      else $error("Interrupt pin not driven.");
   wake_pin_a: assert property (@(posedge clk) disable iff (!rst_b)
      pin_option == PIRS_PIN_OPT_WAKE && wake_event && $stable(pin_option) |=> !int_pin_out)
      else $error("Wake event not driven low.");
   addr_top_a: assert property (@(posedge clk) mgmt_address[4:3] == 2'b00)
      else $error("Address top bits not zero.");
   strap_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      strap_taken_reg && $past(strap_taken_reg) |-> $stable(mgmt_address) && $stable(nand_tree_mode))
      else $error("Strap changed after capture.");
   // The pin is registered, so it follows the polarity that stood when the cause was seen.
   int_level_a: assert property (@(posedge clk) disable iff (!rst_b)
      pin_option != PIRS_PIN_OPT_WAKE && $stable(pin_option) && $stable(phy_ctrl_reg)
      && (|(int_ctrl_reg[7:0] & int_ctrl_reg[15:8])) |=> int_pin_out == $past(phy_ctrl_reg[PIRS_POL_BIT]))
      else $error("Interrupt not active while enabled status set.");
   mode_code_a: assert property (@(posedge clk) !(nand_tree_mode && power_down_mode))
      else $error("Two strap modes at once.");
   clk_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      ref_clock_125_oe_b |-> !ref_clock_125_out)
      else $error("Clock output active while disabled.");
endmodule : pirs_pins
`default_nettype wire

/* verif/pirs_mac_model.sv */
// Management controller model: makes the management clock and data frames.
// Assumes an external pull-up on the data line and the pin block frame layout.
`timescale 1ns/10ps
`default_nettype none
module pirs_mac_model
(
   output logic mgmt_clk,
   output logic mgmt_data_in,
   input wire logic mgmt_data_out,
   input wire logic mgmt_data_oe_b
);
   import pirs_pkg::*;
   logic drv_en; // High while this model drives the line.
   logic drv_d; // Level this model drives.
   // The pull-up wins when nobody drives, so a released line reads one.
   assign mgmt_data_in = (mgmt_data_oe_b === 1'b0) ? mgmt_data_out : (drv_en ? drv_d : 1'b1);
   // The clock stands still outside frames.
   initial
   begin
      mgmt_clk = 1'b0;
      drv_en = 1'b0;
      drv_d = 1'b0;
   end
   // One whole frame; data moves while the clock is low, read data is taken late in the high phase.
   task automatic frame(input logic [1:0] op, input logic [4:0] adr, input logic [15:0] wd,
                        output logic [15:0] rd);
      logic [63:0] bits;
      bits = {32'hffff_ffff, 2'h1, op, 5'h00, adr, 2'h2, wd};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--)
      begin
         mgmt_clk = 1'b0;
         drv_en = !(op == PIRS_OP_READ && i < 18);
         drv_d = bits[i];
         #200;
         mgmt_clk = 1'b1;
         #190;
         if (i < 16)
            rd[i] = mgmt_data_in;
         #10;
      end
      mgmt_clk = 1'b0;
      drv_en = 1'b0;
      #400;
   endtask : frame
endmodule : pirs_mac_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the transceiver pin block.
// Assumes the management controller model and a 20 MHz core clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_count++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module testbench;
   import pirs_pkg::*;
   logic clk, rst_b, mgmt_clk, mgmt_data_in, mgmt_data_out, mgmt_data_oe_b, wake_event;
   logic [7:0] int_events;
   logic [1:0] pin_option;
   logic int_pin_out, int_pin_oe_b, ref_clock_125_in, ref_clock_125_strap_in, ref_clock_125_en_strap;
   logic ref_clock_125_out, ref_clock_125_oe_b, led_behaviour_strap, nand_tree_mode, power_down_mode;
   logic [2:0] mgmt_address_strap;
   logic [3:0] mode_strap;
   logic [4:0] mgmt_address, adr;
   logic [15:0] rd, wd;
   logic [7:0] en;
   logic p, l, e;
   logic [2:0] a;
   int k, err_count, comparisons;
   pirs_pins i_dut (.clk, .rst_b, .mgmt_clk, .mgmt_data_in, .mgmt_data_out, .mgmt_data_oe_b, .int_events,
      .wake_event, .pin_option, .int_pin_out, .int_pin_oe_b, .ref_clock_125_in, .ref_clock_125_strap_in,
      .ref_clock_125_en_strap, .ref_clock_125_out, .ref_clock_125_oe_b, .mgmt_address_strap, .mode_strap,
      .led_behaviour_strap, .mgmt_address, .nand_tree_mode, .power_down_mode);
   pirs_mac_model i_mac (.mgmt_clk, .mgmt_data_in, .mgmt_data_out, .mgmt_data_oe_b);
   // Core clock and the 125 MHz source to be gated.
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      ref_clock_125_in = 1'b0;
      forever #4 ref_clock_125_in = ~ref_clock_125_in;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   // Expected pin level: the polarity level when the pending cause is enabled, else its inverse.
   function automatic logic exp_int_level(input logic en_bit, input logic pol);
      return en_bit ? pol : !pol;
   endfunction : exp_int_level
   // Reset with the given mode strap and random other straps, then scramble the straps to prove they were held.
   task automatic do_reset(input logic [3:0] m, input int n);
      @(negedge clk);
      rst_b = 1'b0;
      mode_strap = m;
      {a, l, e} = 5'($urandom);
      {mgmt_address_strap, ref_clock_125_strap_in, ref_clock_125_en_strap} = {a, l, e};
      repeat (n) @(negedge clk);
      `CHK("int_oe_rst", 1'b0, int_pin_oe_b);
      rst_b = 1'b1;
      @(negedge clk);
      {mgmt_address_strap, ref_clock_125_strap_in, ref_clock_125_en_strap, mode_strap} = ~{a, l, e, m};
      repeat (4) @(negedge clk);
      `CHK("address", {2'b00, a}, mgmt_address);
      `CHK("led", l, led_behaviour_strap);
      `CHK("nand", m == 4'h4, nand_tree_mode);
      `CHK("pdown", m == 4'h7, power_down_mode);
      `CHK("clk_oe", !e, ref_clock_125_oe_b);
      `CHK("int_idle", 1'b1, int_pin_out);
      // Look between two edges of the fast source so both sides have settled.
      #1;
      `CHK("clk_out", e ? ref_clock_125_in : 1'b0, ref_clock_125_out);
   endtask : do_reset
   // Watchdog cut-off, well beyond the expected run time.
   initial
   begin
      #3_000_000;
      err_count++;
      stop_test();
   end
   // Main sequence.
   initial
   begin
      {rst_b, wake_event, int_events, pin_option, mode_strap, mgmt_address_strap} = '0;
      {ref_clock_125_strap_in, ref_clock_125_en_strap, err_count, comparisons} = '0;
      void'($urandom(61));
      do_reset(4'($urandom), 20);
      for (int m = 0; m < 16; m++)
         do_reset(4'(m), 2);
      $display("test straps done");
      for (int i = 0; i < 6; i++)
      begin
         p = 1'($urandom);
         en = (i == 0) ? 8'h00 : 8'($urandom);
         k = $urandom_range(7, 0);
         i_mac.frame(PIRS_OP_WRITE, PIRS_ADDR_PHY_CTRL, {1'b0, p, 14'h0000}, rd);
         i_mac.frame(PIRS_OP_WRITE, PIRS_ADDR_INT_CTRL, {en, 8'h00}, rd);
         @(negedge clk);
         int_events = 8'h01 << k;
         repeat (4) @(negedge clk);
         int_events = 8'h00;
         repeat (6) @(negedge clk);
         `CHK("int_level", exp_int_level(en[k], p), int_pin_out);
         `CHK("int_oe", 1'b0, int_pin_oe_b);
         i_mac.frame(PIRS_OP_READ, PIRS_ADDR_INT_CTRL, 16'h0000, rd);
         `CHK("int_status", {en, 8'h01 << k}, rd);
         repeat (6) @(negedge clk);
         `CHK("int_clear", exp_int_level(1'b0, p), int_pin_out);
         i_mac.frame(PIRS_OP_READ, PIRS_ADDR_PHY_CTRL, 16'h0000, rd);
         `CHK("polarity", {1'b0, p, 14'h0000}, rd);
      end
      $display("test interrupt done");
      pin_option = PIRS_PIN_OPT_WAKE;
      for (int i = 0; i < 2; i++)
      begin
         wake_event = 1'b1 ^ 1'(i);
         repeat (6) @(negedge clk);
         `CHK("wake_pin", 1'(i), int_pin_out);
         `CHK("wake_oe", 1'b0, int_pin_oe_b);
      end
      pin_option = 2'h0;
      $display("test wake done");
      for (int i = 0; i < 4; i++)
      begin
         adr = 5'($urandom_range(26, 0));
         wd = 16'($urandom);
         i_mac.frame(PIRS_OP_WRITE, adr, wd, rd);
         i_mac.frame(PIRS_OP_READ, adr, 16'h0000, rd);
         `CHK("reg_data", wd, rd);
      end
      $display("test registers done");
      stop_test();
   end
endmodule : testbench
`default_nettype wire
